// ==== prog_io.v ====
// four programmable signal lines driving parameter-store accesses
// assumes a parameter store port: req/ack, read data valid with ack
//
// How it works
// - each line role: off, programmable input or programmable output
// - input lines watched continuously; edges detected before the line is granted merge into one access
// - input reacts to rising, falling or both edges; others ignored
// - one index/subindex pair targets both edge polarities
// - separate write values for rising and falling edge
// - edge access: read, AND mask, OR edge value, write back
// - zero mask writes the edge value unchanged
// - output config: index, subindex, mask, comparison value
// - four operators: equal, not equal, less, greater
// - output cycle: read, AND mask, compare, drive line
// - edge code 0 none, 1 rise, 2 fall, 3 both
// - compare code 0 eq, 1 ne, 2 lt, 3 gt
// - line high when comparison holds, low otherwise
`include "prog_io_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module prog_io #(
  parameter POLL_CYCLES = `POLL_CYCLES
) (
  // clock and reset
  input wire core_clk_in,
  input wire rst_n_in,
  // per-line configuration, line n in slice n
  input wire [4*`ROLE_W-1:0] line_role_select_in,
  input wire [4*`IDX_W-1:0] target_param_index_in,
  input wire [4*`SUB_W-1:0] target_param_subindex_in,
  input wire [4*`VAL_W-1:0] access_mask_in,
  input wire [4*`SEL_W-1:0] edge_or_compare_select_in,
  input wire [4*`VAL_W-1:0] rise_value_or_compare_value_in,
  input wire [4*`VAL_W-1:0] fall_write_value_in,
  // signal lines
  input wire [3:0] line_in,
  output wire [3:0] line_out,
  output wire [3:0] line_oe_out,
  // parameter store port
  output wire param_req_out,
  output wire param_we_out,
  output wire [`IDX_W-1:0] param_index_out,
  output wire [`SUB_W-1:0] param_subindex_out,
  output wire [`VAL_W-1:0] param_wdata_out,
  input wire param_ack_in,
  input wire [`VAL_W-1:0] param_rdata_in,
  // status
  output wire [3:0] pending_out,
  output wire busy_out
);
  // ***********************************************
  // functions
  // ***********************************************
  function cmp_holds;
    input [`SEL_W-1:0] op;
    input [`VAL_W-1:0] a;
    input [`VAL_W-1:0] b;
    begin
      case (op)
        `CMP_EQ: cmp_holds = (a == b);
        `CMP_NE: cmp_holds = (a != b);
        `CMP_LT: cmp_holds = (a < b);
        `CMP_GT: cmp_holds = (a > b);
        default: cmp_holds = 1'b0;
      endcase
    end
  endfunction
  function edge_wanted;
    input [`SEL_W-1:0] sel;
    input rise;
    input fall;
    begin
      case (sel)
        `EDGE_NONE: edge_wanted = 1'b0;
        `EDGE_RISE: edge_wanted = rise;
        `EDGE_FALL: edge_wanted = fall;
        `EDGE_BOTH: edge_wanted = rise | fall;
        default: edge_wanted = 1'b0;
      endcase
    end
  endfunction
  function [`ROLE_W-1:0] role_of;
    input [4*`ROLE_W-1:0] roles;
    input [1:0] n;
    begin
      role_of = roles[n*`ROLE_W +: `ROLE_W];
    end
  endfunction

  // ***********************************************
  // edge capture
  // ***********************************************
  wire [3:0] rise_w;
  wire [3:0] fall_w;
  reg [3:0] pend_q;
  reg [3:0] pend_fall_q;
  reg [3:0] poll_due_q;
  reg [3:0] out_q;
  reg [15:0] poll_cnt_q;
  wire poll_tick;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_sync
      line_edge_sync u_sync (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .line_in(line_in[g]),
        .level_out(),
        .rise_out(rise_w[g]),
        .fall_out(fall_w[g])
      );
    end
  endgenerate

  // poll interval enable
  assign poll_tick = (poll_cnt_q == 16'h0000);
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      poll_cnt_q <= 16'h0000;
    end else if (poll_tick) begin
      poll_cnt_q <= POLL_CYCLES[15:0] - 16'h0001;
    end else begin
      poll_cnt_q <= poll_cnt_q - 16'h0001;
    end
  end

  // ***********************************************
  // access sequencer
  // ***********************************************
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_READ = 4'h2;
  localparam [3:0] ST_WRITE = 4'h4;
  localparam [3:0] ST_DONE = 4'h8;
  reg [3:0] state_q;
  reg [1:0] cur_q;
  reg cur_fall_q;
  reg [`VAL_W-1:0] wdata_q;
  reg [3:0] grant;
  reg [1:0] grant_idx;
  wire [3:0] work = pend_q | poll_due_q;
  integer i;
  always @* begin
    grant = 4'h0;
    grant_idx = 2'h0;
    for (i = 3; i >= 0; i = i - 1) begin
      if (work[i]) begin
        grant = 4'h0;
        grant[i] = 1'b1;
        grant_idx = i[1:0];
      end
    end
  end

  wire [`ROLE_W-1:0] cur_role = role_of(line_role_select_in, cur_q);
  wire [`VAL_W-1:0] cur_mask = access_mask_in[cur_q*`VAL_W +: `VAL_W];
  wire [`SEL_W-1:0] cur_sel = edge_or_compare_select_in[cur_q*`SEL_W +: `SEL_W];
  wire [`VAL_W-1:0] cur_v1 = rise_value_or_compare_value_in[cur_q*`VAL_W +: `VAL_W];
  wire [`VAL_W-1:0] cur_v2 = fall_write_value_in[cur_q*`VAL_W +: `VAL_W];
  // zero mask clears the read part, leaving only the edge value
  wire [`VAL_W-1:0] masked = param_rdata_in & cur_mask;
  wire [`VAL_W-1:0] edge_val = cur_fall_q ? cur_v2 : cur_v1;
  wire start = (state_q == ST_IDLE) && (work != 4'h0);
  wire finish = (state_q == ST_DONE);
  reg [3:0] done_mask;
  always @* begin
    done_mask = 4'h0;
    done_mask[cur_q] = finish;
  end

  // ***********************************************
  // parameter address
  // ***********************************************
  // captured at grant so the address cannot move under an access in flight
  reg [`IDX_W-1:0] index_q;
  reg [`SUB_W-1:0] subindex_q;
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      index_q <= 16'h0000;
      subindex_q <= 16'h0000;
    end else if (start) begin
      index_q <= target_param_index_in[grant_idx*`IDX_W +: `IDX_W];
      subindex_q <= target_param_subindex_in[grant_idx*`SUB_W +: `SUB_W];
    end
  end

  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state_q <= ST_IDLE;
      cur_q <= 2'h0;
      cur_fall_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      out_q <= 4'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            cur_q <= grant_idx;
            cur_fall_q <= pend_fall_q[grant_idx];
            state_q <= ST_READ;
          end
        end
        ST_READ: begin
          if (param_ack_in) begin
            if (cur_role == `ROLE_INPUT) begin
              wdata_q <= masked | edge_val;
              state_q <= ST_WRITE;
            end else begin
              if (cur_role == `ROLE_OUTPUT) begin
                out_q[cur_q] <= cmp_holds(cur_sel, masked, cur_v1);
              end
              state_q <= ST_DONE;
            end
          end
        end
        ST_WRITE: begin
          if (param_ack_in) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ***********************************************
  // per-line pending flags
  // ***********************************************
  // pending clears when the line is granted, not when its access ends:
  // an edge arriving during the line's own access queues one more access
  reg [3:0] edge_ev;
  reg [3:0] is_output;
  reg [3:0] pend_d;
  reg [3:0] pend_fall_d;
  reg [3:0] poll_due_d;
  wire [3:0] take = start ? grant : 4'h0;
  integer n;
  always @* begin
    edge_ev = 4'h0;
    is_output = 4'h0;
    pend_d = pend_q;
    pend_fall_d = pend_fall_q;
    poll_due_d = poll_due_q;
    for (n = 0; n < 4; n = n + 1) begin
      is_output[n] = (role_of(line_role_select_in, n[1:0]) == `ROLE_OUTPUT);
      edge_ev[n] = (role_of(line_role_select_in, n[1:0]) == `ROLE_INPUT) &&
        edge_wanted(edge_or_compare_select_in[n*`SEL_W +: `SEL_W], rise_w[n], fall_w[n]);
      // set beats clear
      if (edge_ev[n]) begin
        pend_d[n] = 1'b1;
        pend_fall_d[n] = fall_w[n];
      end else if (take[n]) begin
        pend_d[n] = 1'b0;
      end
      // a tick before a running poll's done cycle is folded into it; set beats clear, so one in that cycle queues another
      if (poll_tick && is_output[n]) begin
        poll_due_d[n] = 1'b1;
      end else if (done_mask[n] || !is_output[n]) begin
        poll_due_d[n] = 1'b0;
      end
    end
  end

  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pend_q <= 4'h0;
      pend_fall_q <= 4'h0;
      poll_due_q <= 4'h0;
    end else begin
      pend_q <= pend_d;
      pend_fall_q <= pend_fall_d;
      poll_due_q <= poll_due_d;
    end
  end

  // ***********************************************
  // outputs
  // ***********************************************
  assign param_req_out = (state_q == ST_READ) || (state_q == ST_WRITE);
  assign param_we_out = (state_q == ST_WRITE);
  assign param_index_out = index_q;
  assign param_subindex_out = subindex_q;
  assign param_wdata_out = wdata_q;
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_oe
      assign line_oe_out[k] = (line_role_select_in[k*`ROLE_W +: `ROLE_W] == `ROLE_OUTPUT);
    end
  endgenerate
  assign line_out = out_q;
  assign pending_out = pend_q;
  assign busy_out = (state_q != ST_IDLE);
endmodule // prog_io
`default_nettype wire

// ==== prog_io_regs.vh ====
// constants for the programmable signal line block
// assumes a single 100 MHz clock and a parameter store with a request/ack port
`ifndef PROG_IO_REGS_VH
`define PROG_IO_REGS_VH
`define LINE_COUNT 4
`define ROLE_W 2
`define ROLE_OFF 2'h0
`define ROLE_INPUT 2'h1
`define ROLE_OUTPUT 2'h2
`define SEL_W 2
`define EDGE_NONE 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3
`define CMP_EQ 2'h0
`define CMP_NE 2'h1
`define CMP_LT 2'h2
`define CMP_GT 2'h3
`define IDX_W 16
`define SUB_W 16
`define VAL_W 32
`define POLL_PERIOD_NS 1000
`define CLK_PERIOD_NS 10
`define POLL_CYCLES (`POLL_PERIOD_NS / `CLK_PERIOD_NS)
`endif

// ==== line_edge_sync.v ====
// synchroniser and edge detector for one signal line
// assumes the line is asynchronous to core_clk_in
`timescale 1ns/1ps
`default_nettype none
module line_edge_sync (
  // clock and reset
  input wire core_clk_in,
  input wire rst_n_in,
  // line
  input wire line_in,
  // level and edges
  output wire level_out,
  output wire rise_out,
  output wire fall_out
);
  reg meta_q;
  reg sync_q;
  reg last_q;
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= line_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end
  assign level_out = sync_q;
  assign rise_out = sync_q & ~last_q;
  assign fall_out = ~sync_q & last_q;
endmodule // line_edge_sync
`default_nettype wire

// ==== prog_io_props.sv ====
// checker for the programmable signal line block
// assumes one clock domain; bound to prog_io below
`timescale 1ns/1ps
`default_nettype none
module prog_io_props (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // watched ports
  input wire logic [7:0] line_role_select_in,
  input wire logic [3:0] line_out,
  input wire logic [3:0] line_oe_out,
  input wire logic param_req_out,
  input wire logic param_we_out,
  input wire logic param_ack_in,
  input wire logic [3:0] pending_out,
  input wire logic busy_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_oe_from_role: assert property (line_oe_out[0] == (line_role_select_in[1:0] == 2'h2))
    else $error("oe wrong");
  a_reset_quiet: assert property ($rose(rst_n_in) |-> !param_req_out && pending_out == 4'h0)
    else $error("not quiet after reset");
  a_req_holds: assert property (param_req_out && !param_ack_in |=> param_req_out)
    else $error("req dropped");
  a_read_first: assert property ($rose(param_req_out) |-> !param_we_out)
    else $error("access not begun by read");
  a_write_after_ack: assert property ($rose(param_we_out) |-> $past(param_ack_in))
    else $error("write before read ack");
  a_write_ends: assert property (param_we_out && param_ack_in |=> !param_req_out [*2])
    else $error("no gap after write");
  a_busy_req: assert property (param_req_out |-> busy_out)
    else $error("req while idle");
  a_level_cause: assert property ($changed(line_out) |-> $past(param_ack_in) || $past(param_ack_in, 2))
    else $error("level moved without read");
  c_write: cover property (param_we_out && param_ack_in);
  c_read: cover property (param_ack_in && !param_we_out);
  c_out_high: cover property ($rose(line_out[2]));
endmodule // prog_io_props
bind prog_io prog_io_props i_prog_io_props (.core_clk_in, .rst_n_in, .line_role_select_in, .line_out,
  .line_oe_out, .param_req_out, .param_we_out, .param_ack_in, .pending_out, .busy_out);
`default_nettype wire

// ==== param_store_model.sv ====
// behavioural parameter store on the req/ack port
// assumes word selected by the low index bits
`timescale 1ns/1ps
`default_nettype none
module param_store_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic slow_in,
  input wire logic req_in,
  input wire logic we_in,
  input wire logic [15:0] index_in,
  input wire logic [31:0] wdata_in,
  output logic ack_out,
  output logic [31:0] rdata_out
);
  logic [31:0] mem [0:15];
  logic [1:0] wait_q;
  always @(posedge clk_in) begin
    if (!rst_n_in || !req_in || ack_out) begin
      ack_out <= 1'b0;
      wait_q <= 2'h0;
      // idle bus never repeats the last word
      rdata_out <= rst_n_in ? ~rdata_out : 32'h0;
    end else if (wait_q == (slow_in ? 2'h3 : 2'h0)) begin
      ack_out <= 1'b1;
      rdata_out <= mem[index_in[3:0]];
      if (we_in) mem[index_in[3:0]] <= wdata_in;
    end else begin
      wait_q <= wait_q + 2'h1;
      rdata_out <= ~rdata_out;
    end
  end
endmodule // param_store_model
`default_nettype wire

// ==== tb_prog_io.sv ====
// self-checking bench: edge accesses on line 0, compare outputs on line 2
// assumes param_store_model as the far side
`timescale 1ns/1ps
`default_nettype none
module tb_prog_io;
  logic clk = 1'b0, rst_n = 1'b0, slow = 1'b0;
  logic [7:0] role = 8'h00, sel = 8'h00;
  logic [63:0] idx = 64'h0000_0005_0000_0000;
  logic [63:0] sub = 64'h0;
  int cur_line = 0;
  logic [127:0] mask = 128'h0, v1 = 128'h0, v2 = 128'h0;
  logic [3:0] lines = 4'h0;
  wire [3:0] lo, oe, pend;
  wire req, we, ack, busy;
  wire [15:0] pidx, psub;
  wire [31:0] wd, rd;
  int failures = 0, num_checks = 0;
  logic [31:0] old, m, a, b, e;
  always #5 clk = ~clk;
  prog_io #(.POLL_CYCLES(8)) i_prog_io (.core_clk_in(clk), .rst_n_in(rst_n), .line_role_select_in(role),
    .target_param_index_in(idx), .target_param_subindex_in(sub), .access_mask_in(mask),
    .edge_or_compare_select_in(sel), .rise_value_or_compare_value_in(v1), .fall_write_value_in(v2),
    .line_in(lines), .line_out(lo), .line_oe_out(oe), .param_req_out(req), .param_we_out(we),
    .param_index_out(pidx), .param_subindex_out(psub), .param_wdata_out(wd), .param_ack_in(ack),
    .param_rdata_in(rd), .pending_out(pend), .busy_out(busy));
  param_store_model i_param_store_model (.clk_in(clk), .rst_n_in(rst_n), .slow_in(slow), .req_in(req),
    .we_in(we), .index_in(pidx), .wdata_in(wd), .ack_out(ack), .rdata_out(rd));
  function automatic logic cmp_hold(input logic [1:0] op, input logic [31:0] x, input logic [31:0] y);
    case (op)
      2'h0: return x == y;
      2'h1: return x != y;
      2'h2: return x < y;
      default: return x > y;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // address of every access, taken at the ack edge
  always @(posedge clk) begin
    if (rst_n && req && ack) begin
      chk({16'h0, pidx}, {16'h0, idx[cur_line*16 +: 16]});
      chk({16'h0, psub}, {16'h0, sub[cur_line*16 +: 16]});
    end
  end
  task automatic settle();
    repeat (6) @(posedge clk);
    for (int i = 0; i < 60 && (busy !== 1'b0 || pend !== 4'h0); i++) @(posedge clk);
  endtask
  task summarize();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #200_000;
    failures++;
    summarize();
  end
  initial begin
    void'($urandom(32'h2822_a6fd));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    role <= 8'h01;
    sub <= {$urandom(), $urandom()};
    // every edge code, rising then falling; zero mask as a corner case
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 2; k++) begin
        old = $urandom();
        m = (s == 3 && k == 0) ? 32'h0 : $urandom();
        a = $urandom();
        b = $urandom();
        i_param_store_model.mem[0] <= old;
        @(posedge clk);
        sel[1:0] <= 2'(s);
        mask[31:0] <= m;
        v1[31:0] <= a;
        v2[31:0] <= b;
        slow <= $urandom() % 2;
        lines[0] <= ~lines[0];
        settle();
        e = s[k] ? ((old & m) | (k ? b : a)) : old;
        chk(i_param_store_model.mem[0], e);
      end
    end
    role <= 8'h20;
    cur_line = 2;
    // compare value below, equal to and above the masked word
    for (int s = 0; s < 8; s++) begin
      old = $urandom();
      m = $urandom();
      a = 32'((old & m) + (s % 3) - 1);
      i_param_store_model.mem[5] <= old;
      @(posedge clk);
      sel[5:4] <= 2'(s);
      mask[95:64] <= m;
      v1[95:64] <= a;
      slow <= s[2];
      repeat (40) @(posedge clk);
      chk({31'h0, lo[2]}, {31'h0, cmp_hold(2'(s), old & m, a)});
      chk({28'h0, oe}, 32'h0000_0004);
    end
    summarize();
  end
endmodule // tb_prog_io
`default_nettype wire
